// *** apa_agen.sv ***
// Auxiliary pointer indirect address generator with Avalon-MM register slave
`timescale 1ns/1ps
module apa_agen
    import apa_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Avalon-MM register slave
    input  wire logic [7:0]            avsAddress,
    input  wire logic                  avsRead,
    input  wire logic                  avsWrite,
    input  wire logic [3:0]            avsByteenable,
    input  wire logic [31:0]           avsWritedata,
    output logic      [31:0]           avsReaddata,
    output logic                       avsWaitrequest,
    // Address generation request
    input  wire logic                  agenReq,
    output logic                       agenReady,
    input  wire logic [2:0]            agenPtr,
    input  apa_space_type              agenSpace,
    input  apa_oper_type               agenOperand,
    input  wire logic                  agenWide,
    input  apa_target_type             agenTarget,
    input  wire logic                  agenBitOp,
    // Address generation result
    output logic                       agenDone,
    output logic                       agenFault,
    output logic      [APA_ADDR_W-1:0] agenDataAddr,
    output logic      [APA_LOW_W-1:0]  agenIoAddr,
    output logic      [5:0]            agenBitNum
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register index decode

    localparam logic [5:0] IDX_XPTR    = APA_OFS_XPTR[7:2];
    localparam logic [5:0] IDX_LOWPTR  = APA_OFS_LOWPTR[7:2];
    localparam logic [5:0] IDX_CIRC    = APA_OFS_CIRC[7:2];
    localparam logic [5:0] IDX_STATUS2 = APA_OFS_STATUS2[7:2];
    localparam logic [5:0] IDX_AGSTAT  = APA_OFS_AGSTAT[7:2];

    // Index fields come from low address bits: blocks must be aligned
    if (APA_PTR_COUNT != 8 || IDX_XPTR[2:0] != 3'h0 || IDX_CIRC[1:0] != 2'h0
        || IDX_LOWPTR - IDX_XPTR != 6'h08 || IDX_CIRC - IDX_LOWPTR != 6'h08) begin : gBadMap
        $error("apa_agen: register map does not fit eight pointers");
    end

    typedef struct packed {
        // Sequencer and latched request
        apa_state_type   state;
        logic [2:0]      reqPtr;
        apa_space_type   reqSpace;
        apa_oper_type    reqOper;
        logic            reqWide;
        apa_target_type  reqTarget;
        logic            reqBitOp;
        // Software-visible configuration and status
        logic [3:0][15:0] circStart;
        logic [7:0]      circEnable;
        logic            modeSelect;
        logic            lastFault;
        logic [7:0]      faultCount;
        // Registered outputs
        logic [31:0]     readData;
        logic            agenDone;
        logic            agenFault;
        logic [APA_ADDR_W-1:0] agenDataAddr;
        logic [APA_LOW_W-1:0]  agenIoAddr;
        logic [5:0]      agenBitNum;
    } apa_main_state_type;

    apa_main_state_type cur;
    apa_main_state_type next_cur;

    logic [5:0]            regIdx;
    logic                  isXptr;
    logic                  isLowPtr;
    logic                  isCirc;
    logic                  takeAgen;
    logic                  takeWrite;
    logic                  takeRead;
    logic [2:0]            memRdAddr;
    logic [APA_ADDR_W-1:0] memRdData;
    logic                  memWrEn;
    logic [2:0]            memWrAddr;
    logic [APA_ADDR_W-1:0] memWrData;
    logic [APA_ADDR_W-1:0] memWrMask;
    logic [APA_ADDR_W-1:0] laneMask;
    logic [APA_ADDR_W-1:0] calcDataAddr;
    logic [APA_LOW_W-1:0]  calcIoAddr;
    logic [5:0]            calcBitNum;
    logic [APA_ADDR_W-1:0] calcNextPtr;
    logic [APA_ADDR_W-1:0] calcPtrMask;
    logic                  calcFault;

    // Each map block is decoded from its range of word indices
    assign regIdx   = avsAddress[7:2];
    assign isXptr   = (regIdx >= IDX_XPTR) && (regIdx < IDX_LOWPTR);
    assign isLowPtr = (regIdx >= IDX_LOWPTR) && (regIdx < IDX_CIRC);
    assign isCirc   = (regIdx >= IDX_CIRC) && (regIdx < IDX_STATUS2);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and generator handshake

    // Generator requests win over the bus; the bus waits in waitrequest
    assign takeAgen  = (cur.state == APA_ST_IDLE) && agenReq;
    assign takeWrite = (cur.state == APA_ST_IDLE) && !agenReq && avsWrite;
    assign takeRead  = (cur.state == APA_ST_IDLE) && !agenReq && avsRead;

    assign agenReady      = (cur.state == APA_ST_IDLE);
    assign avsWaitrequest = !(takeWrite || (cur.state == APA_ST_BUSACK));

    // Lanes 0 to 2 cover the pointer; lane 3 is unused
    assign laneMask = {{APA_HIGH_W{avsByteenable[2]}},
                       {8{avsByteenable[1]}},
                       {8{avsByteenable[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer storage and address arithmetic

    always_comb begin
        memRdAddr = takeAgen ? agenPtr : regIdx[2:0];
        memWrEn   = 1'b0;
        memWrAddr = regIdx[2:0];
        memWrData = avsWritedata[APA_ADDR_W-1:0];
        memWrMask = '0;
        // No bus write collides: the bus waits during writeback
        if (cur.state == APA_ST_AGEN) begin
            memWrEn   = 1'b1;
            memWrAddr = cur.reqPtr;
            memWrData = calcNextPtr;
            memWrMask = calcPtrMask;
        end else if (takeWrite && isXptr) begin
            memWrEn   = 1'b1;
            memWrMask = laneMask;
        end else if (takeWrite && isLowPtr) begin
            memWrEn   = 1'b1;
            memWrMask = {{APA_HIGH_W{1'b0}}, laneMask[APA_LOW_W-1:0]};
        end
    end

    // Read data leave the memory one edge after the address
    apa_ptr_mem #(
        .WIDTH (APA_ADDR_W),
        .DEPTH (APA_PTR_COUNT)
    ) u_ptr_mem (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .rdAddr   (memRdAddr),
        .rdData   (memRdData),
        .wrEn     (memWrEn),
        .wrAddr   (memWrAddr),
        .wrData   (memWrData),
        .wrMask   (memWrMask)
    );

    // Arithmetic sees the request latched at the take edge
    apa_addr_calc u_addr_calc (
        .ptrWord    (memRdData),
        .space      (cur.reqSpace),
        .oper       (cur.reqOper),
        .wide       (cur.reqWide),
        .circEnable (cur.circEnable[cur.reqPtr]),
        .circStart  (cur.circStart[cur.reqPtr[2:1]]),
        .target     (cur.reqTarget),
        .bitOp      (cur.reqBitOp),
        .modeSelect (cur.modeSelect),
        .dataAddr   (calcDataAddr),
        .ioAddr     (calcIoAddr),
        .bitNum     (calcBitNum),
        .nextPtr    (calcNextPtr),
        .ptrMask    (calcPtrMask),
        .fault      (calcFault)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control and register file

    always_comb begin
        next_cur          = cur;
        next_cur.agenDone = 1'b0;
        case (cur.state)
            APA_ST_IDLE: begin
                if (takeAgen) begin
                    // Inputs are sampled at the take edge only
                    next_cur.state     = APA_ST_AGEN;
                    next_cur.reqPtr    = agenPtr;
                    next_cur.reqSpace  = agenSpace;
                    next_cur.reqOper   = agenOperand;
                    next_cur.reqWide   = agenWide;
                    next_cur.reqTarget = agenTarget;
                    next_cur.reqBitOp  = agenBitOp;
                end else if (takeRead) begin
                    next_cur.state = APA_ST_BUSRD;
                end else if (takeWrite) begin
                    // Pointer words go straight to the memory
                    if (isCirc) begin
                        if (avsByteenable[0]) begin
                            next_cur.circStart[regIdx[1:0]][7:0] = avsWritedata[7:0];
                        end
                        if (avsByteenable[1]) begin
                            next_cur.circStart[regIdx[1:0]][15:8] = avsWritedata[15:8];
                        end
                    end else if (regIdx == IDX_STATUS2) begin
                        if (avsByteenable[0]) begin
                            next_cur.circEnable = avsWritedata[APA_CIRC_EN_LSB +: 8];
                        end
                        if (avsByteenable[1]) begin
                            next_cur.modeSelect = avsWritedata[APA_MODE_SEL_BIT];
                        end
                    end
                end
            end
            APA_ST_AGEN: begin
                next_cur.state        = APA_ST_IDLE;
                // A refused access keeps its pointer, addresses read zero
                next_cur.agenDone     = 1'b1;
                next_cur.agenFault    = calcFault;
                next_cur.agenDataAddr = calcFault ? '0 : calcDataAddr;
                next_cur.agenIoAddr   = calcFault ? '0 : calcIoAddr;
                next_cur.agenBitNum   = calcFault ? '0 : calcBitNum;
                next_cur.lastFault    = calcFault;
                if (calcFault) begin
                    next_cur.faultCount = cur.faultCount + 8'h01;
                end
            end
            APA_ST_BUSRD: begin
                next_cur.state    = APA_ST_BUSACK;
                // The pointer word was fetched at the take edge
                next_cur.readData = 32'h00000000;
                if (isXptr) begin
                    next_cur.readData = {9'h000, memRdData};
                end else if (isLowPtr) begin
                    next_cur.readData = {16'h0000, memRdData[APA_LOW_W-1:0]};
                end else if (isCirc) begin
                    next_cur.readData = {16'h0000, cur.circStart[regIdx[1:0]]};
                end else if (regIdx == IDX_STATUS2) begin
                    next_cur.readData[APA_CIRC_EN_LSB +: 8] = cur.circEnable;
                    next_cur.readData[APA_MODE_SEL_BIT]     = cur.modeSelect;
                end else if (regIdx == IDX_AGSTAT) begin
                    next_cur.readData[APA_FAULT_BIT]       = cur.lastFault;
                    next_cur.readData[APA_FCOUNT_LSB +: 8] = cur.faultCount;
                end
            end
            APA_ST_BUSACK: begin
                // Waitrequest is low; the master takes the data here
                next_cur.state = APA_ST_IDLE;
            end
            default: begin
                next_cur.state = APA_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Linear pointers, fault count, start pairs cleared
            cur            <= '0;
            cur.state      <= APA_ST_IDLE;
            cur.circStart  <= {4{APA_CIRC_RST}};
            cur.circEnable <= APA_CIRC_EN_RST;
            cur.modeSelect <= APA_MODE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result outputs

    assign avsReaddata  = cur.readData;
    assign agenDone     = cur.agenDone;
    assign agenFault    = cur.agenFault;
    assign agenDataAddr = cur.agenDataAddr;
    assign agenIoAddr   = cur.agenIoAddr;
    assign agenBitNum   = cur.agenBitNum;

endmodule : apa_agen

// *** apa_pkg.sv ***
// Shared constants and types for the auxiliary pointer indirect address generator
package apa_pkg;

    localparam int APA_PTR_COUNT = 8;
    localparam int APA_LOW_W     = 16;
    localparam int APA_HIGH_W    = 7;
    localparam int APA_ADDR_W    = APA_LOW_W + APA_HIGH_W;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] APA_OFS_XPTR    = 8'h00;
    localparam logic [7:0] APA_OFS_LOWPTR  = 8'h20;
    localparam logic [7:0] APA_OFS_CIRC    = 8'h40;
    localparam logic [7:0] APA_OFS_STATUS2 = 8'h50;
    localparam logic [7:0] APA_OFS_AGSTAT  = 8'h54;

    // Field positions in status_word_two and the generator status word
    localparam int APA_CIRC_EN_LSB  = 0;
    localparam int APA_MODE_SEL_BIT = 15;
    localparam int APA_FAULT_BIT    = 0;
    localparam int APA_FCOUNT_LSB   = 8;

    // Values after reset
    localparam logic [15:0]         APA_CIRC_RST    = 16'h0000;
    localparam logic [7:0]          APA_CIRC_EN_RST = 8'h00;
    localparam logic                APA_MODE_RST    = 1'b0;
    localparam logic [APA_ADDR_W-1:0] APA_PTR_RST   = 23'h000000;

    // Highest bit numbers of register-bit targets
    localparam logic [5:0] APA_ACC_BIT_MAX = 6'h27;
    localparam logic [5:0] APA_REG_BIT_MAX = 6'h0f;

    // Pointer steps
    localparam logic [APA_ADDR_W-1:0] APA_STEP_SINGLE = 23'h000001;
    localparam logic [APA_ADDR_W-1:0] APA_STEP_DOUBLE = 23'h000002;

    typedef enum logic [1:0] {
        APA_SPACE_DATA = 2'h0,
        APA_SPACE_BIT  = 2'h1,
        APA_SPACE_IO   = 2'h2
    } apa_space_type;

    typedef enum logic [1:0] {
        APA_OPER_PLAIN   = 2'h0,
        APA_OPER_POSTINC = 2'h1,
        APA_OPER_POSTDEC = 2'h2
    } apa_oper_type;

    typedef enum logic [1:0] {
        APA_TGT_ACC   = 2'h0,
        APA_TGT_AUX   = 2'h1,
        APA_TGT_TEMP  = 2'h2,
        APA_TGT_OTHER = 2'h3
    } apa_target_type;

    typedef enum logic [1:0] {
        APA_ST_IDLE   = 2'h0,
        APA_ST_BUSRD  = 2'h1,
        APA_ST_BUSACK = 2'h3,
        APA_ST_AGEN   = 2'h2
    } apa_state_type;

endpackage : apa_pkg

// *** apa_ptr_mem.sv ***
// Pointer storage: small memory with bit-masked write and registered read
`timescale 1ns/1ps
module apa_ptr_mem
    import apa_pkg::*;
#(
    parameter int WIDTH = APA_ADDR_W,
    parameter int DEPTH = APA_PTR_COUNT,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData,
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    input  wire logic [WIDTH-1:0] wrMask
);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
        $error("apa_ptr_mem: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0]            rdData;
    } apa_mem_state_type;

    apa_mem_state_type cur;
    apa_mem_state_type next_cur;

    always_comb begin
        next_cur        = cur;
        next_cur.rdData = cur.words[rdAddr];
        if (wrEn) begin
            next_cur.words[wrAddr] = (cur.words[wrAddr] & ~wrMask) | (wrData & wrMask);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign rdData = cur.rdData;

endmodule : apa_ptr_mem

// *** apa_addr_calc.sv ***
// Combinational address forming and pointer step for one indirect access
`timescale 1ns/1ps
module apa_addr_calc
    import apa_pkg::*;
(
    input  wire logic [APA_ADDR_W-1:0] ptrWord,
    input  apa_space_type              space,
    input  apa_oper_type               oper,
    input  wire logic                  wide,
    input  wire logic                  circEnable,
    input  wire logic [APA_LOW_W-1:0]  circStart,
    input  apa_target_type             target,
    input  wire logic                  bitOp,
    input  wire logic                  modeSelect,
    output logic      [APA_ADDR_W-1:0] dataAddr,
    output logic      [APA_LOW_W-1:0]  ioAddr,
    output logic      [5:0]            bitNum,
    output logic      [APA_ADDR_W-1:0] nextPtr,
    output logic      [APA_ADDR_W-1:0] ptrMask,
    output logic                       fault
);

    logic [APA_ADDR_W-1:0] step;
    logic [APA_LOW_W-1:0]  low;
    logic [5:0]            bitLimit;
    logic [APA_ADDR_W-1:0] lowMask;

    always_comb begin
        step     = wide ? APA_STEP_DOUBLE : APA_STEP_SINGLE;
        low      = ptrWord[APA_LOW_W-1:0];
        lowMask  = {{APA_HIGH_W{1'b0}}, {APA_LOW_W{1'b1}}};
        bitLimit = ((target == APA_TGT_ACC) ? APA_ACC_BIT_MAX : APA_REG_BIT_MAX)
                   - {5'h00, wide};

        // Circular start offset applies only when this pointer runs circular
        dataAddr = circEnable ? ptrWord + {{APA_HIGH_W{1'b0}}, circStart}
                              : ptrWord;
        ioAddr   = low;
        bitNum   = low[5:0];

        fault = modeSelect;
        case (space)
            APA_SPACE_BIT: begin
                if (!bitOp || target == APA_TGT_OTHER) begin
                    fault = 1'b1;
                end
                if (low > {10'h000, bitLimit}) begin
                    fault = 1'b1;
                end
            end
            APA_SPACE_IO: begin
                if (wide) begin
                    fault = 1'b1;
                end
            end
            default: begin
            end
        endcase

        nextPtr = ptrWord;
        ptrMask = '0;
        if (space == APA_SPACE_DATA) begin
            // Full-width step carries across main data pages
            case (oper)
                APA_OPER_POSTINC: begin
                    nextPtr = ptrWord + step;
                    ptrMask = '1;
                end
                APA_OPER_POSTDEC: begin
                    nextPtr = ptrWord - step;
                    ptrMask = '1;
                end
                default: begin
                end
            endcase
        end else begin
            // I/O addresses and bit numbers wrap in the low half only
            case (oper)
                APA_OPER_POSTINC: begin
                    nextPtr = {ptrWord[APA_ADDR_W-1:APA_LOW_W], low + step[APA_LOW_W-1:0]};
                    ptrMask = lowMask;
                end
                APA_OPER_POSTDEC: begin
                    nextPtr = {ptrWord[APA_ADDR_W-1:APA_LOW_W], low - step[APA_LOW_W-1:0]};
                    ptrMask = lowMask;
                end
                default: begin
                end
            endcase
        end
        if (fault) begin
            ptrMask = '0;
        end
    end

endmodule : apa_addr_calc

// *** apa_agen_checker.sv ***
// Port-level checks for the auxiliary pointer address generator
`timescale 1ns/1ps
module apa_agen_checker
    import apa_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  reset_n,
    input wire logic                  avsRead,
    input wire logic                  avsWrite,
    input wire logic                  avsWaitrequest,
    input wire logic                  agenReq,
    input wire logic                  agenReady,
    input apa_space_type              agenSpace,
    input wire logic                  agenWide,
    input apa_target_type             agenTarget,
    input wire logic                  agenBitOp,
    input wire logic                  agenDone,
    input wire logic                  agenFault,
    input wire logic [APA_ADDR_W-1:0] agenDataAddr,
    input wire logic [APA_LOW_W-1:0]  agenIoAddr,
    input wire logic [5:0]            agenBitNum
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic bitTake;
    assign take = agenReq && agenReady;
    assign bitTake = take && agenSpace == APA_SPACE_BIT;
    sequence s_gen;
        !agenReady ##1 (agenDone && agenReady);
    endsequence
    sequence s_rd;
        avsWaitrequest ##1 avsWaitrequest ##1 !avsWaitrequest;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_gen_latency: assert property (take |=> s_gen)
        else $error("generator result not two cycles after take");
    a_fault_zeroes: assert property (agenDone && agenFault |->
        agenDataAddr == '0 && agenIoAddr == '0 && agenBitNum == '0)
        else $error("refused access left a nonzero address");
    a_bit_io_agree: assert property (agenDone |-> agenBitNum == agenIoAddr[5:0])
        else $error("bit number differs from low pointer");
    a_bit_refused: assert property (bitTake && (agenTarget == APA_TGT_OTHER || !agenBitOp)
        |=> ##1 agenFault)
        else $error("illegal bit access not refused");
    a_io_wide: assert property (take && agenSpace == APA_SPACE_IO && agenWide
        |=> ##1 agenFault)
        else $error("long-word io access not refused");
    a_acc_limit: assert property (bitTake && agenTarget == APA_TGT_ACC
        |=> ##1 (agenFault || agenBitNum <= APA_ACC_BIT_MAX))
        else $error("accumulator bit number above limit");
    a_reg_limit: assert property (bitTake && agenTarget inside {APA_TGT_AUX, APA_TGT_TEMP}
        |=> ##1 (agenFault || agenBitNum <= APA_REG_BIT_MAX))
        else $error("register bit number above limit");
    a_write_nowait: assert property (avsWrite && agenReady && !agenReq |-> !avsWaitrequest)
        else $error("idle write was made to wait");
    a_read_latency: assert property (avsRead && agenReady && !agenReq |-> s_rd)
        else $error("register read answer not on third cycle");
endmodule : apa_agen_checker

bind apa_agen apa_agen_checker apa_agen_checker_inst (
    .core_clk(core_clk), .reset_n(reset_n), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWaitrequest(avsWaitrequest), .agenReq(agenReq), .agenReady(agenReady),
    .agenSpace(agenSpace), .agenWide(agenWide), .agenTarget(agenTarget),
    .agenBitOp(agenBitOp), .agenDone(agenDone), .agenFault(agenFault),
    .agenDataAddr(agenDataAddr), .agenIoAddr(agenIoAddr), .agenBitNum(agenBitNum)
);

// *** apa_agen_tb.sv ***
// Self-checking bench for the auxiliary pointer address generator
`timescale 1ns/1ps
module apa_agen_tb
    import apa_pkg::*;
;
    localparam apa_space_type  D = APA_SPACE_DATA;
    localparam apa_space_type  B = APA_SPACE_BIT;
    localparam apa_space_type  I = APA_SPACE_IO;
    localparam apa_oper_type   PL = APA_OPER_PLAIN;
    localparam apa_oper_type   PI = APA_OPER_POSTINC;
    localparam apa_oper_type   PD = APA_OPER_POSTDEC;
    localparam apa_target_type AC = APA_TGT_ACC;
    localparam apa_target_type AX = APA_TGT_AUX;
    localparam apa_target_type TM = APA_TGT_TEMP;
    localparam apa_target_type OT = APA_TGT_OTHER;
    logic                  core_clk, reset_n, avsRead, avsWrite, avsWaitrequest;
    logic [7:0]            avsAddress;
    logic [3:0]            avsByteenable = 4'hf;
    logic [31:0]           avsWritedata, avsReaddata;
    logic                  agenReq, agenReady, agenWide, agenBitOp, agenDone, agenFault;
    logic [2:0]            agenPtr;
    apa_space_type         agenSpace;
    apa_oper_type          agenOperand;
    apa_target_type        agenTarget;
    logic [APA_ADDR_W-1:0] agenDataAddr;
    logic [APA_LOW_W-1:0]  agenIoAddr;
    logic [5:0]            agenBitNum;
    int                    mismatches = 0, checked = 0, cycles = 0, nFault = 0;

    apa_agen apa_agen_inst (
        .core_clk(core_clk), .reset_n(reset_n), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
        .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .agenReq(agenReq),
        .agenReady(agenReady), .agenPtr(agenPtr), .agenSpace(agenSpace),
        .agenOperand(agenOperand), .agenWide(agenWide), .agenTarget(agenTarget),
        .agenBitOp(agenBitOp), .agenDone(agenDone), .agenFault(agenFault),
        .agenDataAddr(agenDataAddr), .agenIoAddr(agenIoAddr), .agenBitNum(agenBitNum)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= 1'b1;
        do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        @(posedge core_clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
        got = avsReaddata;
        avsRead <= 1'b0;
        chk(got, exp);
    endtask : rdchk

    // Flags f: wide, bit instruction, expected refusal
    task automatic gen(input int p, input apa_space_type s, input apa_oper_type o,
                       input apa_target_type t, input logic [2:0] f, input logic [31:0] ev);
        @(posedge core_clk);
        agenPtr <= 3'(p);
        agenSpace <= s;
        agenOperand <= o;
        agenTarget <= t;
        agenWide <= f[2];
        agenBitOp <= f[1];
        agenReq <= 1'b1;
        do @(posedge core_clk); while (agenReady !== 1'b1);
        agenReq <= 1'b0;
        do @(posedge core_clk); while (agenDone !== 1'b1);
        nFault += int'(f[0]);
        chk(32'(agenFault), 32'(f[0]));
        chk(s == D ? 32'(agenDataAddr) : s == I ? 32'(agenIoAddr) : 32'(agenBitNum), ev);
    endtask : gen

    initial begin
        {avsAddress, avsRead, avsWrite, avsWritedata, agenReq, agenPtr} = '0;
        {agenWide, agenBitOp} = '0;
        agenSpace = D;
        agenOperand = PL;
        agenTarget = AC;
        reset_n = 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            rdchk(8'(4 * n), 32'h0);
            wr(8'(4 * n), 32'(32'hff000000 + 32'h10000 * (n + 1) + n));
            rdchk(8'(4 * n), 32'(32'h10000 * (n + 1) + n));
            rdchk(8'(32 + 4 * n), 32'(n));
            gen(3'(n), D, PL, AC, 3'b010, 32'(32'h10000 * (n + 1) + n));
        end
        wr(8'h60, 32'hffffffff);
        rdchk(8'h60, 32'h0);
        wr(8'h2c, 32'hffff1234);
        rdchk(8'h0c, 32'h00041234);
        wr(8'h00, 32'h1fffe);
        gen(0, D, PI, AC, 3'b110, 32'h1fffe);
        gen(0, D, PL, AC, 3'b010, 32'h20000);
        gen(0, D, PD, AC, 3'b010, 32'h20000);
        gen(0, D, PD, AC, 3'b110, 32'h1ffff);
        gen(0, D, PI, AC, 3'b010, 32'h1fffd);
        gen(0, D, PL, AC, 3'b010, 32'h1fffe);
        wr(8'h00, 32'h7fffff);
        gen(0, D, PI, AC, 3'b010, 32'h7fffff);
        gen(0, D, PL, AC, 3'b010, 32'h0);
        wr(8'h14, 32'h12ffff);
        gen(5, I, PI, AC, 3'b010, 32'hffff);
        gen(5, I, PD, AC, 3'b010, 32'h0);
        gen(5, D, PL, AC, 3'b010, 32'h12ffff);
        gen(5, I, PL, AC, 3'b111, 32'h0);
        wr(APA_OFS_CIRC + 8'h04, 32'h0100);
        wr(APA_OFS_STATUS2, 32'h04);
        rdchk(APA_OFS_STATUS2, 32'h04);
        rdchk(APA_OFS_CIRC + 8'h04, 32'h0100);
        wr(8'h08, 32'h030010);
        gen(2, D, PL, AC, 3'b010, 32'h030110);
        gen(2, I, PL, AC, 3'b010, 32'h0010);
        gen(3, D, PL, AC, 3'b010, 32'h041234);
        wr(APA_OFS_STATUS2, 32'h0);
        wr(8'h10, 32'h27);
        gen(4, B, PL, AC, 3'b010, 32'h27);
        gen(4, B, PL, AC, 3'b111, 32'h0);
        wr(8'h30, 32'h0f);
        gen(4, B, PL, AX, 3'b010, 32'h0f);
        gen(4, B, PL, TM, 3'b111, 32'h0);
        gen(4, B, PL, OT, 3'b011, 32'h0);
        gen(4, B, PL, TM, 3'b001, 32'h0);
        wr(8'h30, 32'h02);
        gen(4, B, PI, AX, 3'b110, 32'h02);
        gen(4, B, PD, TM, 3'b010, 32'h04);
        gen(4, B, PL, AC, 3'b010, 32'h03);
        wr(APA_OFS_STATUS2, 32'h8000);
        gen(1, D, PL, AC, 3'b011, 32'h0);
        rdchk(APA_OFS_AGSTAT, {16'h0, nFault[7:0], 8'h01});
        wr(APA_OFS_STATUS2, 32'h0);
        gen(1, D, PL, AC, 3'b010, 32'h20001);
        rdchk(APA_OFS_AGSTAT, {16'h0, nFault[7:0], 8'h00});
        tally_and_finish();
    end
endmodule : apa_agen_tb
